// [design/apd_defines.vh]
// Constants for the automatic power-down manager
`ifndef APD_DEFINES_VH
`define APD_DEFINES_VH
`define IDLE_CLOCKS          4'hf
`define CNT_W                4
`define REG_A_TURBO_OFF_BIT  3
`define REG_A_CLK_ARRAY_BIT  4
`define REG_A_CLK_MCELL_BIT  5
`define REG_C_ADDR_LO_BIT    0
`define REG_C_CTRL0_BIT      2
`define REG_C_CTRL1_BIT      3
`define REG_C_CTRL2_BIT      4
`define REG_C_STROBE_BIT     5
`define REG_C_WRH_BIT        6
`define REG_RESET_VAL        8'h00
`define TURBO_IDLE_NS        70
`define CLOCK_NS             10
`define TURBO_IDLE_CYC       ((`TURBO_IDLE_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`endif

// [design/auto_powerdown_unit.v]
// Automatic power-down unit, power management registers and signal blocking
//
// How it works
// - Four-bit counter on external clock flags power-down after fifteen idle clocks
// - Enabling the unit enables power-down entry while chip-select is high and reset-exit low
// - Strobe pulsing again returns device to normal operation
// - Chip-select low or reset-exit input high also leaves power-down
// - In power-down host bus is blocked from memories and logic arrays
// - Memories in standby during power-down; logic and ports keep working
// - Power-down: I/O holds, latched address undefined, data/peripheral pins tri-state
// - Masking external clock from logic never masks it from the counter
// - Power-down leaves logic behaviour alone; only turbo bit sets speed
// - Register A bit 3 is turbo off when 1; default 0
// - Turbo off: logic standby after 70 ns with no input switching
// - Host writes power registers at run time; set bits block inputs
// - Register A bits 4 and 5 block clock from array and macrocells
// - Register C bits 0,2-6 block address byte, controls, strobe, write-high
// - Chip-select low enables memories; high disables them, logic keeps running
// - Counter clears when disabled, strobe pulsing or exit active; counts at idle polarity
`timescale 1ns/1ns
`include "apd_defines.vh"

module auto_powerdown_unit #(
  parameter CNT_W = `CNT_W
) (
  input  wire       clock,
  input  wire       rstn,
  input  wire       ext_clock_in,
  input  wire       address_strobe_in,
  input  wire       strobe_idle_high,
  input  wire       apd_enable,
  input  wire       chip_select_n,
  input  wire       reset_exit_in,
  input  wire       reg_wr_a,
  input  wire       reg_wr_c,
  input  wire [7:0] reg_wdata,
  input  wire [7:0] host_addr_lo,
  input  wire       control_in_0,
  input  wire       control_in_1,
  input  wire       control_in_2,
  input  wire       high_byte_write_enable,
  input  wire       port_drive_en,
  output reg  [7:0] power_mgmt_reg_a,
  output reg  [7:0] power_mgmt_reg_c,
  output reg        powerdown_flag,
  output wire       host_bus_block,
  output wire       memory_enable,
  output wire       memory_standby,
  output wire       data_port_oe,
  output wire       addr_out_valid,
  output wire       turbo_on,
  output reg        logic_standby,
  output wire       array_clock,
  output wire       mcell_clock,
  output wire [7:0] array_addr_lo,
  output wire       array_ctrl_0,
  output wire       array_ctrl_1,
  output wire       array_ctrl_2,
  output wire       array_strobe,
  output wire       array_wrh
);

  reg             rst_meta_ff;
  reg             rst_sync_ff;
  reg             extclk_prev_ff;
  reg             strobe_prev_ff;
  reg [CNT_W-1:0] count_ff;
  reg [CNT_W-1:0] nxt_count;
  reg             nxt_powerdown;
  reg [3:0]       idle_ff;
  reg [12:0]      inputs_prev_ff;

  wire            rst_n_int = rst_sync_ff;
  wire            ext_tick = ext_clock_in & ~extclk_prev_ff;
  wire            strobe_edge = address_strobe_in ^ strobe_prev_ff;
  wire            strobe_idle = address_strobe_in == strobe_idle_high;
  wire            exit_cond = ~chip_select_n | reset_exit_in;
  wire [12:0]     array_inputs = {array_addr_lo, array_ctrl_0, array_ctrl_1,
                                  array_ctrl_2, array_strobe, array_wrh};

  // Counter decisions
  wire            hold_count = ~apd_enable | strobe_edge | exit_cond;
  wire            tick_ok    = ext_tick & strobe_idle;
  wire            last_tick  = count_ff == `IDLE_CLOCKS - 4'h1;

  // Saturating step parks the count at fifteen until an exit clears it
  function [CNT_W-1:0] sat_step;
    input [CNT_W-1:0] value;
    begin
      if (value == `IDLE_CLOCKS)
        sat_step = value;
      else
        sat_step = value + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // One gate per array input; power-down blocks the host bus as well
  function gate_bit;
    input in_bit;
    input block_bit;
    input pd_bit;
    begin
      gate_bit = in_bit & ~block_bit & ~pd_bit;
    end
  endfunction

  function [7:0] gate_byte;
    input [7:0] in_byte;
    input       block_bit;
    input       pd_bit;
    begin
      gate_byte = in_byte & {8{~block_bit & ~pd_bit}};
    end
  endfunction

  // Reset released through two flops; only the second is used downstream
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Power registers: host writes at run time, cleared only by power-on reset
  always @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      power_mgmt_reg_a <= `REG_RESET_VAL;
      power_mgmt_reg_c <= `REG_RESET_VAL;
    end else begin
      if (reg_wr_a)
        power_mgmt_reg_a <= reg_wdata;
      if (reg_wr_c)
        power_mgmt_reg_c <= reg_wdata;
    end
  end

  // Counter sees the raw external clock, never the masked copies
  // Exit wins over a tick in the same cycle, so a waking host
  // never loses the race against a late count
  always @* begin
    nxt_count     = count_ff;
    nxt_powerdown = powerdown_flag;
    if (hold_count) begin
      nxt_count     = {CNT_W{1'b0}};
      nxt_powerdown = 1'b0;
    end else if (tick_ok) begin
      if (last_tick)
        nxt_powerdown = 1'b1;
      nxt_count = sat_step(count_ff);
    end
  end

  always @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      extclk_prev_ff <= 1'b0;
      strobe_prev_ff <= 1'b0;
      count_ff       <= {CNT_W{1'b0}};
      powerdown_flag <= 1'b0;
    end else begin
      extclk_prev_ff <= ext_clock_in;
      strobe_prev_ff <= address_strobe_in;
      count_ff       <= nxt_count;
      powerdown_flag <= nxt_powerdown;
    end
  end

  // Logic standby tracks only turbo and input activity, not power-down
  // Sees the gated array inputs, so blocked pins do not keep it awake
  // Idle time rounded up to whole clocks
  always @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      inputs_prev_ff <= 13'h0000;
      idle_ff        <= 4'h0;
      logic_standby  <= 1'b0;
    end else begin
      inputs_prev_ff <= array_inputs;
      if (turbo_on || array_inputs != inputs_prev_ff) begin
        idle_ff       <= 4'h0;
        logic_standby <= 1'b0;
      end else if (idle_ff != `TURBO_IDLE_CYC) begin
        idle_ff <= idle_ff + 4'h1;
      end else begin
        logic_standby <= 1'b1;
      end
    end
  end

  // Memory side follows select and power-down; logic side never stops
  // Address outputs are flagged invalid rather than held in power-down
  // Data port released so the host bus can float while asleep
  assign turbo_on       = ~power_mgmt_reg_a[`REG_A_TURBO_OFF_BIT];
  assign host_bus_block = powerdown_flag;
  assign memory_enable  = ~chip_select_n & ~powerdown_flag;
  assign memory_standby = ~memory_enable;
  assign data_port_oe   = port_drive_en & ~powerdown_flag;
  assign addr_out_valid = ~powerdown_flag;

  // Clock masks for the logic; the counter above uses ext_clock_in directly
  assign array_clock = ext_clock_in & ~power_mgmt_reg_a[`REG_A_CLK_ARRAY_BIT];
  assign mcell_clock = ext_clock_in & ~power_mgmt_reg_a[`REG_A_CLK_MCELL_BIT];

  // Blocked inputs and host bus in power-down read as zero to the arrays
  // Strobe blocking does not hide activity from the counter above
  assign array_addr_lo = gate_byte(host_addr_lo, power_mgmt_reg_c[`REG_C_ADDR_LO_BIT],
                                   powerdown_flag);
  assign array_ctrl_0  = gate_bit(control_in_0, power_mgmt_reg_c[`REG_C_CTRL0_BIT],
                                  powerdown_flag);
  assign array_ctrl_1  = gate_bit(control_in_1, power_mgmt_reg_c[`REG_C_CTRL1_BIT],
                                  powerdown_flag);
  assign array_ctrl_2  = gate_bit(control_in_2, power_mgmt_reg_c[`REG_C_CTRL2_BIT],
                                  powerdown_flag);
  assign array_strobe  = gate_bit(address_strobe_in, power_mgmt_reg_c[`REG_C_STROBE_BIT],
                                  powerdown_flag);
  assign array_wrh     = gate_bit(high_byte_write_enable, power_mgmt_reg_c[`REG_C_WRH_BIT],
                                  powerdown_flag);

endmodule // auto_powerdown_unit

// [bench/apd_monitor.sv]
// Port checker for the power-down unit
`timescale 1ns/1ns
module apd_monitor (
  input logic       clock,
  input logic       rstn,
  input logic       address_strobe_in,
  input logic       apd_enable,
  input logic       chip_select_n,
  input logic       reset_exit_in,
  input logic       reg_wr_a,
  input logic [7:0] reg_wdata,
  input logic [7:0] power_mgmt_reg_a,
  input logic       powerdown_flag,
  input logic       memory_enable,
  input logic       data_port_oe,
  input logic       turbo_on
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_busy; $changed(address_strobe_in); endsequence
  property p_busy; s_busy |=> !powerdown_flag; endproperty
  property p_cs; !chip_select_n |=> !powerdown_flag; endproperty
  property p_rex; reset_exit_in |=> !powerdown_flag; endproperty
  property p_off; !apd_enable |=> !powerdown_flag; endproperty
  property p_mem; memory_enable == (!chip_select_n && !powerdown_flag); endproperty
  property p_oe; powerdown_flag |-> !data_port_oe; endproperty
  property p_turbo; turbo_on == !power_mgmt_reg_a[3]; endproperty
  property p_wr; reg_wr_a |=> power_mgmt_reg_a == $past(reg_wdata); endproperty
  a_busy: assert property (p_busy)
    else $error("strobe exit missed");
  a_cs: assert property (p_cs)
    else $error("select exit missed");
  a_rex: assert property (p_rex)
    else $error("reset exit missed");
  a_off: assert property (p_off)
    else $error("flag while disabled");
  a_mem: assert property (p_mem)
    else $error("memory enable wrong");
  a_oe: assert property (p_oe)
    else $error("port driven in power-down");
  a_turbo: assert property (p_turbo)
    else $error("turbo wrong");
  a_wr: assert property (p_wr)
    else $error("write lost");
endmodule // apd_monitor
bind auto_powerdown_unit apd_monitor apd_monitor_i (.*);

// [bench/host_bus_model.sv]
// Host bus model: address strobe and external clock
`timescale 1ns/1ns
module host_bus_model (
  input  logic clock,
  input  logic act,
  output logic address_strobe_in,
  output logic ext_clock_in
);
  logic [1:0] div_ff = 2'h0;
  initial address_strobe_in = 1'b0;
  // Idle host rests the strobe low, the idle level
  always @(negedge clock) begin
    div_ff <= div_ff + 2'h1;
    address_strobe_in <= act & ~address_strobe_in;
  end
  assign ext_clock_in = div_ff[1];
endmodule // host_bus_model

// [bench/auto_powerdown_unit_tb.sv]
// Self-checking bench for the power-down unit
`timescale 1ns/1ns
module auto_powerdown_unit_tb;
  logic clock = 0, rstn = 0, en = 0, csn = 1, rex = 0, wa = 0, wc = 0, act = 0, pde = 0;
  logic [7:0] wd = 8'h00, ra, alo, rc;
  logic [4:0] arr;
  logic       sih = 0;
  logic       stb, ext, pd, hbb, msb, doe, aov, trb, lsb, aclk, mclk;
  int         num_errors = 0, checked = 0, cyc = 0;
  host_bus_model host_bus_model_i (.clock(clock), .act(act), .address_strobe_in(stb),
    .ext_clock_in(ext));
  auto_powerdown_unit auto_powerdown_unit_i (.clock(clock), .rstn(rstn), .ext_clock_in(ext),
    .address_strobe_in(stb), .strobe_idle_high(sih), .apd_enable(en), .chip_select_n(csn),
    .reset_exit_in(rex), .reg_wr_a(wa), .reg_wr_c(wc), .reg_wdata(wd), .host_addr_lo(8'hff),
    .control_in_0(1'b1), .control_in_1(1'b1), .control_in_2(1'b1),
    .high_byte_write_enable(1'b1), .port_drive_en(pde), .power_mgmt_reg_a(ra),
    .power_mgmt_reg_c(rc), .powerdown_flag(pd), .host_bus_block(hbb), .memory_enable(),
    .memory_standby(msb), .data_port_oe(doe), .addr_out_valid(aov), .turbo_on(trb),
    .logic_standby(lsb), .array_clock(aclk), .mcell_clock(mclk), .array_addr_lo(alo),
    .array_ctrl_0(arr[4]), .array_ctrl_1(arr[3]), .array_ctrl_2(arr[2]),
    .array_strobe(arr[1]), .array_wrh(arr[0]));
  always #5 clock = ~clock;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("Checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock) if (++cyc > 2000) begin
    num_errors++;
    end_of_test;
  end
  task wr(input logic a, input logic [7:0] d);
    @(negedge clock);
    {wa, wc, wd} = {a, !a, d};
    @(negedge clock);
    {wa, wc} = 2'h0;
  endtask
  task t_regs;
    chk({ra[3], trb}, 8'h01);
    wr(1, 8'h38);
    chk({trb, aclk, mclk}, 8'h00);
    wr(0, 8'h7d);
    chk(alo, 8'h00);
    chk(rc, 8'h7d);
    chk(8'(arr), 8'h00);
    wr(0, 8'h00);
    chk(alo, 8'hff);
    chk(8'(arr), 8'h1d);
    repeat (9) @(negedge clock);
    chk(lsb, 8'h01);
  endtask
  // Ticks counted from the design's own view of the clock; it stays masked from the logic
  task t_entry;
    int   n;
    logic p;
    n = 0;
    @(posedge clock);
    p = ext;
    @(negedge clock);
    en = 1;
    repeat (100) begin
      @(posedge clock);
      if (pd) break;
      if (ext && !p) n++;
      p = ext;
    end
    chk(8'(n), 8'h0f);
  endtask
  // Strobe resting off the idle polarity must never count
  task t_polarity;
    sih = 1;
    en = 1;
    repeat (80) @(negedge clock);
    chk(pd, 8'h00);
    sih = 0;
    repeat (70) @(negedge clock);
    chk(pd, 8'h01);
    en = 0;
    @(negedge clock);
    chk(pd, 8'h00);
  endtask
  task t_exit;
    for (int k = 0; k < 3; k++) begin
      t_entry;
      @(negedge clock);
      pde = 1;
      chk({hbb, msb, doe, aov, alo[0]}, 8'h18);
      chk(8'(arr), 8'h00);
      {act, csn, rex} = {k == 0, k != 1, k == 2};
      repeat (3) @(negedge clock);
      chk({pd, msb}, {7'h00, k != 1});
      {act, csn, rex, en, pde} = 5'h08;
      @(negedge clock);
    end
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rstn = 1;
    repeat (3) @(negedge clock);
    t_regs;
    t_polarity;
    t_exit;
    end_of_test;
  end
endmodule // auto_powerdown_unit_tb
